// >>> design/vbc_pkg.sv
// constants, types and register map of the oscillator band calibration block
// assumes an apb master on the same clock as the block
package vbc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] VBC_OFS_CFG    = 12'h000;
  localparam logic [11:0] VBC_OFS_CAL    = 12'h004;
  localparam logic [11:0] VBC_OFS_STAT   = 12'h008;
  localparam int          VBC_MODE_LSB   = 0;
  localparam int          VBC_AUTO_BIT   = 5;
  localparam int          VBC_GATE_BIT   = 6;
  localparam int          VBC_SWING_LSB  = 8;
  localparam int          VBC_START_BIT  = 0;
  localparam int          VBC_LOCK_BIT   = 1;
  localparam int          VBC_SD_BIT     = 2;
  localparam int          VBC_BAND_LSB   = 8;
  localparam logic [4:0]  VBC_MODE_RST   = 5'h00;
  localparam logic [1:0]  VBC_SWING_RST  = 2'h0;

  // ************************************************************
  // calibration
  // ************************************************************
  localparam int          VBC_NUM_BANDS  = 32;
  localparam logic [4:0]  VBC_BAND_MID   = 5'h10;
  localparam logic [2:0]  VBC_BIT_TOP    = 3'h4;
  localparam int          VBC_CAL_TICKS  = 7;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    VBC_IDLE   = 4'b0001,
    VBC_SETTLE = 4'b0010,
    VBC_SEARCH = 4'b0100,
    VBC_DONE   = 4'b1000
  } vbc_state_t;

  typedef enum logic [1:0] {
    VBC_DIRECT = 2'h0,
    VBC_DIV2   = 2'h1,
    VBC_DIV4   = 2'h2
  } vbc_div_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vbc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } vbc_apb_rsp_t;

  typedef struct packed {
    logic       cp_inhibit;
    logic       tuning_voltage_pin_mid;
    logic [4:0] band;
    logic [1:0] swing;
    logic       osc_a_en;
    logic       osc_b_en;
    logic       ext_buf_en;
    vbc_div_t   div_sel;
    logic       out_en;
    logic       power_en;
  } vbc_ana_t;

  typedef struct packed {
    logic        lock_s1;
    logic        lock_s2;
    logic        lock_q;
    logic        pfd_s1;
    logic        pfd_s2;
    logic        pfd_q;
    logic        hi_s1;
    logic        hi_s2;
    logic        sd_s1;
    logic        sd_s2;
    logic [4:0]  mode;
    logic        auto_en;
    logic        gate;
    logic [1:0]  swing;
    vbc_state_t  st;
    logic [2:0]  bit_idx;
    logic [4:0]  band;
    logic [31:0] prdata;
  } vbc_q_t;

endpackage : vbc_pkg

// >>> design/vbc_top.sv
// oscillator sub-band calibration and output path control
// assumes apb on clk; lock, pfd tick, comparator and shutdown pin are async
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
module vbc_top (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // register bus
  input  vbc_pkg::vbc_apb_req_t apb_req,
  output vbc_pkg::vbc_apb_rsp_t apb_rsp,
  // analog side, asynchronous inputs
  input  wire logic          lock_detect,
  input  wire logic          pfd_clk,
  input  wire logic          freq_above_target,
  input  wire logic          external_shutdown_pin,
  // analog controls
  output vbc_pkg::vbc_ana_t  ana
);

  vbc_pkg::vbc_q_t q_q;
  vbc_pkg::vbc_q_t q_d;

  logic        setup;
  logic        wr;
  logic        mapped;
  logic        busy;
  logic        tick;
  logic        lock_fall;
  logic        start_wr;
  logic        trigger;
  logic [31:0] rdata;
  logic [4:0]  bit_mask;

  // ************************************************************
  // bus decode
  // ************************************************************
  assign setup  = apb_req.psel && !apb_req.penable;
  assign wr     = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign mapped = (apb_req.paddr == vbc_pkg::VBC_OFS_CFG)
               || (apb_req.paddr == vbc_pkg::VBC_OFS_CAL)
               || (apb_req.paddr == vbc_pkg::VBC_OFS_STAT);

  // read data is captured in the setup cycle so that it comes from a flop
  assign apb_rsp.prdata  = q_q.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

  // ************************************************************
  // events
  // ************************************************************
  assign busy      = (q_q.st != vbc_pkg::VBC_IDLE);
  assign tick      = q_q.pfd_s2 && !q_q.pfd_q;
  assign lock_fall = q_q.lock_q && !q_q.lock_s2;
  assign start_wr  = wr && (apb_req.paddr == vbc_pkg::VBC_OFS_CAL)
                  && apb_req.pwdata[vbc_pkg::VBC_START_BIT];
  // start or auto restart; busy blocks retrigger
  assign trigger   = !busy && (start_wr || (lock_fall && q_q.auto_en));
  assign bit_mask  = 5'h01 << q_q.bit_idx;

  always_comb begin
    rdata = 32'h0;
    case (apb_req.paddr)
      vbc_pkg::VBC_OFS_CFG: begin
        rdata[vbc_pkg::VBC_MODE_LSB +: 5]  = q_q.mode;
        rdata[vbc_pkg::VBC_AUTO_BIT]       = q_q.auto_en;
        rdata[vbc_pkg::VBC_GATE_BIT]       = q_q.gate;
        rdata[vbc_pkg::VBC_SWING_LSB +: 2] = q_q.swing;
      end
      vbc_pkg::VBC_OFS_CAL: begin
        rdata[vbc_pkg::VBC_START_BIT] = busy;
      end
      vbc_pkg::VBC_OFS_STAT: begin
        rdata[vbc_pkg::VBC_START_BIT]     = busy;
        rdata[vbc_pkg::VBC_LOCK_BIT]      = q_q.lock_s2;
        rdata[vbc_pkg::VBC_SD_BIT]        = q_q.sd_s2;
        rdata[vbc_pkg::VBC_BAND_LSB +: 5] = q_q.band;
      end
      default: begin
        rdata = 32'h0;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    q_d = q_q;
    q_d.lock_s1 = lock_detect;
    q_d.lock_s2 = q_q.lock_s1;
    q_d.lock_q  = q_q.lock_s2;
    q_d.pfd_s1  = pfd_clk;
    q_d.pfd_s2  = q_q.pfd_s1;
    q_d.pfd_q   = q_q.pfd_s2;
    q_d.hi_s1   = freq_above_target;
    q_d.hi_s2   = q_q.hi_s1;
    q_d.sd_s1   = external_shutdown_pin;
    q_d.sd_s2   = q_q.sd_s1;
    if (setup) begin
      q_d.prdata = rdata;
    end
    if (wr && (apb_req.paddr == vbc_pkg::VBC_OFS_CFG)) begin
      q_d.mode    = apb_req.pwdata[vbc_pkg::VBC_MODE_LSB +: 5];
      q_d.auto_en = apb_req.pwdata[vbc_pkg::VBC_AUTO_BIT];
      q_d.gate    = apb_req.pwdata[vbc_pkg::VBC_GATE_BIT];
      q_d.swing   = apb_req.pwdata[vbc_pkg::VBC_SWING_LSB +: 2];
    end
    case (q_q.st)
      vbc_pkg::VBC_IDLE: begin
        if (trigger) begin
          q_d.st = vbc_pkg::VBC_SETTLE;
        end
      end
      vbc_pkg::VBC_SETTLE: begin
        // first trial is the middle band
        if (tick) begin
          q_d.band    = vbc_pkg::VBC_BAND_MID;
          q_d.bit_idx = vbc_pkg::VBC_BIT_TOP;
          q_d.st      = vbc_pkg::VBC_SEARCH;
        end
      end
      vbc_pkg::VBC_SEARCH: begin
        // successive approximation over the 32 bands
        if (tick) begin
          if (q_q.hi_s2) begin
            q_d.band = q_q.band & ~bit_mask;
          end
          if (q_q.bit_idx == 3'h0) begin
            q_d.st = vbc_pkg::VBC_DONE;
          end else begin
            q_d.band    = (q_q.hi_s2 ? (q_q.band & ~bit_mask) : q_q.band)
                        | (bit_mask >> 1);
            q_d.bit_idx = q_q.bit_idx - 3'h1;
          end
        end
      end
      vbc_pkg::VBC_DONE: begin
        // seventh tick ends the run and frees the pump
        if (tick) begin
          q_d.st = vbc_pkg::VBC_IDLE;
        end
      end
      default: begin
        q_d.st = vbc_pkg::VBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= '{st:      vbc_pkg::VBC_IDLE,
               mode:    vbc_pkg::VBC_MODE_RST,
               swing:   vbc_pkg::VBC_SWING_RST,
               default: '0};
    end else begin
      q_q <= q_d;
    end
  end

  // ************************************************************
  // analog controls
  // ************************************************************
  logic powered;

  always_comb begin
    ana            = '0;
    // pump inhibit and mid-supply hold while running
    ana.cp_inhibit = busy;
    ana.tuning_voltage_pin_mid  = busy;
    ana.band       = q_q.band;
    // swing code passed straight to the amplitude control
    ana.swing      = q_q.swing;
    ana.div_sel    = vbc_pkg::VBC_DIV2;
    // mode decode, unlisted codes power down
    case (q_q.mode)
      5'h01: ana.osc_a_en = 1'b1;
      5'h02: ana.osc_b_en = 1'b1;
      5'h03: ana.ext_buf_en = 1'b1;
      5'h04: begin
        ana.osc_a_en = 1'b1;
        ana.div_sel  = vbc_pkg::VBC_DIRECT;
      end
      5'h05: begin
        ana.osc_b_en = 1'b1;
        ana.div_sel  = vbc_pkg::VBC_DIRECT;
      end
      5'h06: begin
        ana.ext_buf_en = 1'b1;
        ana.div_sel    = vbc_pkg::VBC_DIRECT;
      end
      5'h07: begin
        ana.osc_a_en = 1'b1;
        ana.div_sel  = vbc_pkg::VBC_DIV4;
      end
      5'h08: begin
        ana.osc_b_en = 1'b1;
        ana.div_sel  = vbc_pkg::VBC_DIV4;
      end
      5'h09: begin
        ana.ext_buf_en = 1'b1;
        ana.div_sel    = vbc_pkg::VBC_DIV4;
      end
      default: ana.div_sel = vbc_pkg::VBC_DIV2;
    endcase
    powered = ana.osc_a_en || ana.osc_b_en || ana.ext_buf_en;
    if (!q_q.gate && q_q.sd_s2) begin
      ana.osc_a_en   = 1'b0;
      ana.osc_b_en   = 1'b0;
      ana.ext_buf_en = 1'b0;
      ana.power_en   = 1'b0;
    end else begin
      ana.power_en   = powered;
    end
    ana.out_en = ana.power_en && !q_q.sd_s2;
  end

  // ************************************************************
  // checks
  // ************************************************************
  localparam logic [2:0] TICKS_BEFORE_END = 3'(vbc_pkg::VBC_CAL_TICKS - 1);
  logic [2:0] tick_cnt_q;

  // counts comparison ticks seen since the run began
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 3'h0;
    end else if (!busy) begin
      tick_cnt_q <= 3'h0;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_begins: assert property (
    !busy && start_wr |=> q_q.st == vbc_pkg::VBC_SETTLE && ana.cp_inhibit)
    else $error("start write did not begin calibration");

  a_pump_held: assert property (
    busy |-> ana.cp_inhibit && ana.tuning_voltage_pin_mid)
    else $error("pump not inhibited during calibration");

  a_self_clear: assert property (
    q_q.st == vbc_pkg::VBC_DONE && tick |=> !busy && !ana.cp_inhibit)
    else $error("start bit did not self clear");

  a_seven_ticks: assert property (
    q_q.st == vbc_pkg::VBC_DONE && tick |-> tick_cnt_q == TICKS_BEFORE_END)
    else $error("calibration length is not seven ticks");

  a_auto_restart: assert property (
    !busy && lock_fall && q_q.auto_en |=> q_q.st == vbc_pkg::VBC_SETTLE)
    else $error("lock loss did not restart calibration");

  a_no_auto: assert property (
    !busy && lock_fall && !q_q.auto_en && !start_wr |=> !busy)
    else $error("restart without auto enable");

  a_busy_ignore: assert property (
    busy && lock_fall && !tick |=> $stable(q_q.st) && $stable(q_q.band))
    else $error("lock loss disturbed running calibration");

  a_power_down: assert property (
    !q_q.gate && q_q.sd_s2 |-> !ana.power_en && !ana.out_en)
    else $error("shutdown pin did not power down");

  a_output_gate: assert property (
    q_q.gate && q_q.mode == 5'h01 |-> ana.power_en && ana.out_en != q_q.sd_s2)
    else $error("output gate mode wrong");

  a_mode_off: assert property (
    q_q.mode == 5'h00 |-> !ana.osc_a_en && !ana.osc_b_en && !ana.ext_buf_en)
    else $error("mode zero not powered down");

  a_pin_sync: assert property (
    !q_q.gate && q_q.mode == 5'h01
      |-> ana.power_en == !$past(external_shutdown_pin, 2))
    else $error("shutdown pin not seen through two flops");

endmodule : vbc_top

// >>> sim/vbc_ana_model.sv
// loop model: comparison clock, trial band comparator and lock detect
// assumes the bench sets the lock state and the target sub-band
module vbc_ana_model (
  // from the bench
  input  wire logic       lock_want,
  input  wire logic [4:0] target,
  // from the block
  input  wire logic [4:0] band,
  // towards the block
  output logic            lock_detect,
  output logic            pfd_clk,
  output logic            freq_above_target
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // comparison clock
  // ************************************************************
  // rate stays at 1 MHz, never raised after calibrating
  initial pfd_clk = 1'b0;
  always #500 pfd_clk = ~pfd_clk;

  // ************************************************************
  // oscillator and lock
  // ************************************************************
  // a higher band code runs faster
  assign freq_above_target = band > target;
  assign lock_detect = lock_want;

endmodule : vbc_ana_model

// >>> sim/tb_top.sv
// bench for the band calibration block, apb tasks and the loop model
// assumes a single 200 MHz clock and no wait states on apb
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk       = 1'b0;
  logic                  rst_n     = 1'b0;
  logic                  sd_pin    = 1'b0;
  logic                  lock_want = 1'b0;
  logic [4:0]            target    = 5'h00;
  logic                  lock_detect;
  logic                  pfd_clk;
  logic                  above;
  vbc_pkg::vbc_apb_req_t req       = '0;
  vbc_pkg::vbc_apb_rsp_t rsp;
  vbc_pkg::vbc_ana_t     ana;
  int                    bad_count = 0;
  int                    n_tests   = 0;
  int                    cyc       = 0;

  always #2.5 clk = ~clk;

  vbc_ana_model vbc_ana_model_i (
    .lock_want(lock_want), .target(target), .band(ana.band),
    .lock_detect(lock_detect), .pfd_clk(pfd_clk),
    .freq_above_target(above));

  vbc_top vbc_top_i (
    .clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .lock_detect(lock_detect), .pfd_clk(pfd_clk),
    .freq_above_target(above), .external_shutdown_pin(sd_pin), .ana(ana));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test

  // one transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) begin
      @(posedge clk);
    end
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    // an idle edge keeps the next request out of this time step
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rdc

  // waits out a calibration, counting comparison clock ticks
  task automatic run_cal(output int ticks);
    logic p;
    int   n;
    ticks = 0;
    n = 0;
    p = pfd_clk;
    while (ana.cp_inhibit === 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
      if (pfd_clk && !p) ticks++;
      p = pfd_clk;
    end
  endtask : run_cal

  task automatic wait_inhibit();
    int n;
    n = 0;
    while (ana.cp_inhibit !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_inhibit

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    int          modes[11];
    logic [4:0]  m;
    logic [4:0]  tg[3];
    logic [31:0] r;
    logic        e;
    int          t;
    modes = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10};
    tg = '{5'h0b, 5'h1f, 5'h00};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(ana.div_sel, 32'h1);
    check(ana, 32'h0004);
    rdc(vbc_pkg::VBC_OFS_CFG, 32'h0);
    rdc(vbc_pkg::VBC_OFS_STAT, 32'h0);
    $display("test reset done");
    foreach (modes[i]) begin
      m = modes[i][4:0];
      wr(vbc_pkg::VBC_OFS_CFG, {22'h0, m[1:0], 3'h0, m});
      @(posedge clk);
      t = (m == 0 || m > 9) ? 0 : 4 >> ((m - 1) % 3);
      check({ana.osc_a_en, ana.osc_b_en, ana.ext_buf_en}, t);
      if (m != 0)
        check(ana.div_sel, (m <= 3 || m > 9) ? 1 : (m <= 6) ? 0 : 2);
      check(ana.swing, m[1:0]);
      rdc(vbc_pkg::VBC_OFS_CFG, {22'h0, m[1:0], 3'h0, m});
    end
    $display("test modes done");
    apb(1'b1, 12'h00c, 32'h1, r, e);
    check(e, 1'b1);
    apb(1'b0, 12'h00c, 32'h0, r, e);
    check(r, 32'h0);
    $display("test unmapped done");
    wr(vbc_pkg::VBC_OFS_CFG, 32'h1);
    foreach (tg[i]) begin
      target <= tg[i];
      // new target for every start
      wr(vbc_pkg::VBC_OFS_CAL, 32'h1);
      @(posedge clk);
      check({ana.cp_inhibit, ana.tuning_voltage_pin_mid}, 2'b11);
      rdc(vbc_pkg::VBC_OFS_CAL, 32'h1);
      run_cal(t);
      check(ana.band, tg[i]);
      check(t >= 6 && t <= 8, 1'b1);
      @(posedge clk);
      check(ana.cp_inhibit, 1'b0);
      rdc(vbc_pkg::VBC_OFS_STAT, {19'h0, tg[i], 8'h0});
    end
    $display("test calibration done");
    target <= 5'h15;
    wr(vbc_pkg::VBC_OFS_CFG, 32'h21);
    lock_want <= 1'b1;
    repeat (6) @(posedge clk);
    lock_want <= 1'b0;
    wait_inhibit();
    check(ana.cp_inhibit, 1'b1);
    repeat (20) @(posedge clk);
    lock_want <= 1'b1;
    repeat (20) @(posedge clk);
    lock_want <= 1'b0;
    run_cal(t);
    check(ana.band, 5'h15);
    repeat (10) @(posedge clk);
    check(ana.cp_inhibit, 1'b0);
    wr(vbc_pkg::VBC_OFS_CFG, 32'h1);
    lock_want <= 1'b1;
    repeat (6) @(posedge clk);
    lock_want <= 1'b0;
    repeat (10) @(posedge clk);
    check(ana.cp_inhibit, 1'b0);
    $display("test restart done");
    check({ana.power_en, ana.out_en}, 2'b11);
    sd_pin    <= 1'b1;
    lock_want <= 1'b1;
    repeat (2) @(posedge clk);
    check(ana.power_en, 1'b1);
    repeat (4) @(posedge clk);
    check({ana.power_en, ana.out_en}, 2'b00);
    rdc(vbc_pkg::VBC_OFS_STAT, {19'h0, 5'h15, 8'h06});
    wr(vbc_pkg::VBC_OFS_CFG, 32'h41);
    @(posedge clk);
    check({ana.power_en, ana.out_en}, 2'b10);
    sd_pin <= 1'b0;
    repeat (6) @(posedge clk);
    check({ana.power_en, ana.out_en}, 2'b11);
    $display("test shutdown done");
    stop_test();
  end

endmodule : tb_top
